// File: design/csi_slave_defs.vh
`ifndef CSI_SLAVE_DEFS_VH
`define CSI_SLAVE_DEFS_VH

// Channel operating clock and the fastest external serial clock it can follow
`define CSI_MCK_HZ           50000000
`define CSI_MCK_PER_SCK_MIN  6

// Index of the last bit of a word, per word length
`define CSI_LAST_BIT_8       3'h7
`define CSI_LAST_BIT_7       3'h6

// Reset values
`define CSI_COUNT_RST        3'h0
`define CSI_WORD_RST         8'h00
`define CSI_LINE_IDLE        1'b1

// Cycles after reset before the synchroniser output is trusted for edges
`define CSI_WARM_RST         2'h0
`define CSI_WARM_DONE        2'h3

`endif

// File: design/csi_slave_channel.v
`timescale 1ns/1ns
`include "csi_slave_defs.vh"

// Contract
// RQ1 - The serial clock comes from the master, is sampled on the channel clock and may run up to a sixth of it.
// RQ2 - In receive-only mode the interrupt fires only at transfer end; the buffer-empty source is not used.
// RQ3 - In transmit-receive mode the interrupt fires at transfer end or on buffer empty, as software selects.
// RQ4 - The only error flagged is overrun, when a received word is not taken before the next one completes.
// RQ5 - In receive mode data phase 0 samples from the first clock activity, data phase 1 half a clock earlier.
// RQ6 - In transmit-receive mode data phase shifts both driving and sampling the same way.
// RQ7 - Clock phase 0 reads the serial clock forward, clock phase 1 reversed.
// RQ8 - Software keeps the external clock no faster than half the configured transfer clock.
// RQ9 - In receive-only mode the output enable plays no part; only clock and data inputs are used.
// RQ10 - Software starts the channel by writing 1 only to this channel's start bit.
// RQ11 - After the unit clock was stopped while halted, software waits for the master and reinitialises.
// RQ12 - Words are seven or eight bits long in both modes, as configured.
// RQ13 - Data is shifted most or least significant bit first, as configured.
// RQ14 - Writing transmit data while the buffer is full overwrites the buffered data.
// RQ15 - Software loads transmit data before the master starts the clock.
// RQ16 - The interrupt source select may change in operation, before the last bit of the final word.
// RQ17 - Writing the stop bit halts the channel and clears its active flag.
module csi_slave_channel (
  // Clock and reset
  input  wire       clock,
  input  wire       rst,
  // Serial pins
  input  wire       serial_clock_pin,
  input  wire       serial_data_in_pin,
  output reg        serial_data_out_pin,
  // Configuration
  input  wire       transceive_mode,
  input  wire       interrupt_source_select,
  input  wire       data_phase_select,
  input  wire       clock_phase_select,
  input  wire       lsb_first,
  input  wire       word_len_7,
  input  wire       output_enable_register,
  // Control strobes
  input  wire       channel_start,
  input  wire       channel_stop_bit,
  input  wire       tx_write,
  input  wire [7:0] tx_data,
  input  wire       rx_read,
  input  wire       overrun_clear,
  // Status
  output reg        channel_active_flag,
  output reg        buffer_full_flag,
  output reg        rx_full_flag,
  output reg  [7:0] rx_data,
  output reg        overrun_flag,
  output reg        channel_transfer_interrupt
);

  reg       sck_s1_q;
  reg       sck_s2_q;
  reg       sck_prev_q;
  reg       sdi_s1_q;
  reg       sdi_s2_q;
  reg [7:0] tx_buf_q;
  reg [7:0] tx_sr_q;
  reg [7:0] rx_sr_q;
  reg [2:0] count_q;
  reg       loaded_q;
  reg       bit_q;
  reg [1:0] warm_q;

  wire       sck_now  = sck_s2_q ^ clock_phase_select;     // [RQ7]
  wire       sck_was  = sck_prev_q ^ clock_phase_select;
  // No edges until the synchroniser has filled, so a pin idling low gives no false edge
  wire       settled  = (warm_q == `CSI_WARM_DONE);
  wire       lead     = settled & sck_was & ~sck_now;
  wire       trail    = settled & ~sck_was & sck_now;
  // Data phase 1 samples at the first edge, phase 0 at the second
  wire       sample   = data_phase_select ? lead : trail;  // [RQ5] [RQ6]
  wire       drive    = data_phase_select ? trail : lead;  // [RQ6]
  wire [2:0] last_bit = word_len_7 ? `CSI_LAST_BIT_7 : `CSI_LAST_BIT_8; // [RQ12]
  wire       word_end = channel_active_flag & sample & (count_q == last_bit);
  wire       load_now = channel_active_flag & transceive_mode & buffer_full_flag
                        & ~loaded_q & (count_q == `CSI_COUNT_RST) & sck_now;

  // Bit to put on the line next, from the given word
  function pick;
    input [7:0] w;
    input       lsb;
    input       len7;
    begin
      if (lsb) begin
        pick = w[0];
      end else if (len7) begin
        pick = w[6];
      end else begin
        pick = w[7];
      end
    end
  endfunction

  // Word after one bit has left the line
  function [7:0] shift_out;
    input [7:0] w;
    input       lsb;
    begin
      if (lsb) begin
        shift_out = {1'b0, w[7:1]};
      end else begin
        shift_out = {w[6:0], 1'b0};
      end
    end
  endfunction

  // Received word, right aligned for seven-bit words
  function [7:0] assemble;
    input [7:0] w;
    input       b;
    input       lsb;
    input       len7;
    reg   [7:0] t;
    begin
      t = lsb ? {b, w[7:1]} : {w[6:0], b};
      if (lsb & len7) begin
        assemble = {1'b0, t[7:1]};
      end else if (len7) begin
        assemble = {1'b0, t[6:0]};
      end else begin
        assemble = t;
      end
    end
  endfunction

  // Two-stage synchronisers; third flop feeds edge detection
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      sck_s1_q   <= `CSI_LINE_IDLE;
      sck_s2_q   <= `CSI_LINE_IDLE;
      sck_prev_q <= `CSI_LINE_IDLE;
      sdi_s1_q   <= `CSI_LINE_IDLE;
      sdi_s2_q   <= `CSI_LINE_IDLE;
      warm_q     <= `CSI_WARM_RST;
    end else begin
      if (warm_q != `CSI_WARM_DONE) begin
        warm_q <= warm_q + 2'h1;
      end
      sck_s1_q   <= serial_clock_pin;                      // [RQ1]
      sck_s2_q   <= sck_s1_q;
      sck_prev_q <= sck_s2_q;
      sdi_s1_q   <= serial_data_in_pin;                    // [RQ9]
      sdi_s2_q   <= sdi_s1_q;
    end
  end

  // Start, stop and bit counting
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      channel_active_flag <= 1'b0;
      count_q             <= `CSI_COUNT_RST;
    end else if (channel_stop_bit) begin
      channel_active_flag <= 1'b0;                         // [RQ17]
      count_q             <= `CSI_COUNT_RST;
    end else if (channel_start) begin
      channel_active_flag <= 1'b1;
      count_q             <= `CSI_COUNT_RST;
    end else if (word_end) begin
      count_q <= `CSI_COUNT_RST;
    end else if (channel_active_flag & sample) begin
      count_q <= count_q + 3'h1;
    end
  end

  // Transmit buffer and shifter
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_buf_q         <= `CSI_WORD_RST;
      buffer_full_flag <= 1'b0;
      tx_sr_q          <= `CSI_WORD_RST;
      loaded_q         <= 1'b0;
      bit_q            <= `CSI_LINE_IDLE;
    end else begin
      if (tx_write) begin
        tx_buf_q         <= tx_data;                       // [RQ14]
        buffer_full_flag <= 1'b1;
      end else if (load_now) begin
        buffer_full_flag <= 1'b0;
      end
      if (channel_stop_bit | channel_start | word_end) begin
        loaded_q <= 1'b0;
      end else if (load_now) begin
        loaded_q <= 1'b1;
      end
      if (load_now & data_phase_select) begin
        // First bit goes out at load, ahead of the first edge
        bit_q   <= pick(tx_buf_q, lsb_first, word_len_7); // [RQ6] [RQ13]
        tx_sr_q <= shift_out(tx_buf_q, lsb_first);
      end else if (load_now) begin
        tx_sr_q <= tx_buf_q;
      end else if (channel_active_flag & drive & ~word_end) begin
        bit_q   <= pick(tx_sr_q, lsb_first, word_len_7);  // [RQ13]
        tx_sr_q <= shift_out(tx_sr_q, lsb_first);
      end
    end
  end

  // Output pin driven only in transmit-receive mode with output enabled
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      serial_data_out_pin <= `CSI_LINE_IDLE;
    end else begin
      serial_data_out_pin <= (transceive_mode & output_enable_register) ? bit_q : `CSI_LINE_IDLE; // [RQ9]
    end
  end

  // Receive shifter, received word and overrun
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_sr_q      <= `CSI_WORD_RST;
      rx_data      <= `CSI_WORD_RST;
      rx_full_flag <= 1'b0;
      overrun_flag <= 1'b0;
    end else begin
      if (channel_active_flag & sample) begin
        rx_sr_q <= lsb_first ? {sdi_s2_q, rx_sr_q[7:1]} : {rx_sr_q[6:0], sdi_s2_q}; // [RQ5] [RQ13]
      end
      if (word_end) begin
        rx_data      <= assemble(rx_sr_q, sdi_s2_q, lsb_first, word_len_7); // [RQ12]
        rx_full_flag <= 1'b1;
      end else if (rx_read) begin
        rx_full_flag <= 1'b0;
      end
      // Set wins over clear
      if (word_end & rx_full_flag & ~rx_read) begin
        overrun_flag <= 1'b1;                              // [RQ4]
      end else if (overrun_clear) begin
        overrun_flag <= 1'b0;
      end
    end
  end

  // One-cycle interrupt pulse; source select is read live each event
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      channel_transfer_interrupt <= 1'b0;
    end else if (transceive_mode & interrupt_source_select) begin
      channel_transfer_interrupt <= load_now;              // [RQ3] [RQ16]
    end else begin
      channel_transfer_interrupt <= word_end;              // [RQ2] [RQ3]
    end
  end

endmodule

// File: tb/csi_slave_assertions.sv
`timescale 1ns/1ns
module csi_slave_assertions (
  // Watched ports
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       serial_data_out_pin,
  input wire logic       transceive_mode,
  input wire logic       interrupt_source_select,
  input wire logic       output_enable_register,
  input wire logic       word_len_7,
  input wire logic       channel_stop_bit,
  input wire logic       rx_read,
  input wire logic       overrun_clear,
  input wire logic       channel_active_flag,
  input wire logic       buffer_full_flag,
  input wire logic       rx_full_flag,
  input wire logic [7:0] rx_data,
  input wire logic       overrun_flag,
  input wire logic       channel_transfer_interrupt
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  quiet_out_a: assert property (!(transceive_mode && output_enable_register) [*2] |-> serial_data_out_pin)
    else $error("output driven");
  rx_irq_end_a: assert property (channel_transfer_interrupt && !$past(transceive_mode) |-> rx_full_flag)
    else $error("irq without word");
  empty_irq_a: assert property ($fell(buffer_full_flag) && $past(interrupt_source_select)
    && $past(transceive_mode) |-> channel_transfer_interrupt) else $error("no empty irq");
  stop_halts_a: assert property (channel_stop_bit |=> !channel_active_flag) else $error("still active");
  idle_quiet_a: assert property (!channel_active_flag && !$past(channel_active_flag)
    |-> !channel_transfer_interrupt) else $error("irq while idle");
  overrun_set_a: assert property (channel_transfer_interrupt && !$past(transceive_mode) && $past(rx_full_flag)
    && !$past(rx_read) |-> overrun_flag) else $error("overrun missed");
  overrun_hold_a: assert property (overrun_flag && !overrun_clear |=> overrun_flag) else $error("overrun lost");
  len7_align_a: assert property (word_len_7 && $past(word_len_7) && $changed(rx_data) |-> !rx_data[7])
    else $error("bit 7 set");
  cover property ($rose(overrun_flag));
  cover property (channel_transfer_interrupt && transceive_mode && interrupt_source_select);
  cover property ($fell(channel_active_flag));
endmodule
bind csi_slave_channel csi_slave_assertions u_chk (
  .clock                      (clock),
  .rst                        (rst),
  .serial_data_out_pin        (serial_data_out_pin),
  .transceive_mode            (transceive_mode),
  .interrupt_source_select    (interrupt_source_select),
  .output_enable_register     (output_enable_register),
  .word_len_7                 (word_len_7),
  .channel_stop_bit           (channel_stop_bit),
  .rx_read                    (rx_read),
  .overrun_clear              (overrun_clear),
  .channel_active_flag        (channel_active_flag),
  .buffer_full_flag           (buffer_full_flag),
  .rx_full_flag               (rx_full_flag),
  .rx_data                    (rx_data),
  .overrun_flag               (overrun_flag),
  .channel_transfer_interrupt (channel_transfer_interrupt)
);

// File: tb/csi_master_model.sv
`timescale 1ns/1ns
module csi_master_model (
  // Bench side
  input  wire logic       go,
  input  wire logic [7:0] word,
  input  wire logic [3:0] nbits,
  input  wire logic       cps,
  input  wire logic       dap,
  output logic            busy,
  output logic [7:0]      got,
  // Serial pins
  input  wire logic       serial_data_out_pin,
  output wire logic       serial_clock_pin,
  output logic            serial_data_in_pin
);
  logic lead = '0;
  assign serial_clock_pin = lead ^ !cps;  // Idle level follows clock phase
  initial begin
    busy = '0;
    got = '0;
    serial_data_in_pin = '1;
  end
  always @(posedge go) begin
    busy = '1;
    #7;
    for (int i = nbits - 1; i >= 0; i--) begin
      if (dap) serial_data_in_pin = word[i];
      // Data phase 1: every bit is ready before its leading edge
      #79 if (dap || i < nbits - 1) got = {got[6:0], serial_data_out_pin};
      #1 lead = '1;  // 80 ns phases stay within the rated rate
      if (!dap) serial_data_in_pin = word[i];
      #80 lead = '0;
    end
    #79 if (!dap) got = {got[6:0], serial_data_out_pin};
    #1 serial_data_in_pin = !serial_data_in_pin;  // Released line shows the inverse
    busy = '0;
  end
endmodule

// File: tb/tb_csi_slave_channel.sv
`timescale 1ns/1ns
module tb_csi_slave_channel;
  logic        clock = '0, rst = '1, tm = '0, dap = '0, cps = '0, lsb = '0, oe = '0, go = '0, rxf_q = '0;
  logic        word_len_7 = '0, interrupt_source_select = '0, channel_start = '0, channel_stop_bit = '0;
  logic        tx_write = '0, rx_read = '0, overrun_clear = '0;
  logic        serial_clock_pin, serial_data_in_pin, serial_data_out_pin, busy, channel_active_flag;
  logic        buffer_full_flag, rx_full_flag, overrun_flag, channel_transfer_interrupt;
  logic [7:0]  tx_data = '0, word = '0, d, t, m, got, rx_data;
  logic [3:0]  nbits = 4'h8;
  logic [31:0] rs = 32'h7;
  logic [7:0]  expq[$];
  int          errors = 0, num_checks = 0;
  csi_slave_channel dut (
    .clock                      (clock),
    .rst                        (rst),
    .serial_clock_pin           (serial_clock_pin),
    .serial_data_in_pin         (serial_data_in_pin),
    .serial_data_out_pin        (serial_data_out_pin),
    .transceive_mode            (tm),
    .interrupt_source_select    (interrupt_source_select),
    .data_phase_select          (dap),
    .clock_phase_select         (cps),
    .lsb_first                  (lsb),
    .word_len_7                 (word_len_7),
    .output_enable_register     (oe),
    .channel_start              (channel_start),
    .channel_stop_bit           (channel_stop_bit),
    .tx_write                   (tx_write),
    .tx_data                    (tx_data),
    .rx_read                    (rx_read),
    .overrun_clear              (overrun_clear),
    .channel_active_flag        (channel_active_flag),
    .buffer_full_flag           (buffer_full_flag),
    .rx_full_flag               (rx_full_flag),
    .rx_data                    (rx_data),
    .overrun_flag               (overrun_flag),
    .channel_transfer_interrupt (channel_transfer_interrupt)
  );
  csi_master_model u_master (
    .go                  (go),
    .word                (word),
    .nbits               (nbits),
    .cps                 (cps),
    .dap                 (dap),
    .busy                (busy),
    .got                 (got),
    .serial_data_out_pin (serial_data_out_pin),
    .serial_clock_pin    (serial_clock_pin),
    .serial_data_in_pin  (serial_data_in_pin)
  );
  initial forever #10 clock = ~clock;
  function logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  function logic [7:0] rev(input logic [7:0] v, input logic [3:0] k);
    rev = '0;
    for (int i = 0; i < k; i++) rev[k - 1 - i] = v[i];
  endfunction
  task chk(input logic ok, input string s);
    num_checks++;
    if (!ok) begin
      errors++;
      $display("Error %0t: %s", $time, s);
    end
  endtask
  task end_sim;
    $display("Checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task send(input logic rd);
    d = rs[31:24] & m;
    expq.push_back(d);
    word <= lsb ? rev(d, nbits) : d;
    @(posedge clock) go <= '1;
    @(posedge clock) go <= '0;
    for (int k = 0; k < 200 && busy !== 1'b0; k++) @(posedge clock);
    chk(busy === 1'b0, "master hang");
    repeat (8) @(posedge clock);
    rx_read <= rd;
    @(posedge clock) rx_read <= '0;
  endtask
  always @(posedge clock) begin
    rxf_q <= rx_full_flag;
    if ((rx_full_flag === 1'b1 && rxf_q === 1'b0) || (channel_transfer_interrupt === 1'b1 && !tm)) begin
      chk(expq.size() > 0 && rx_data === expq[0], "rx word");
      if (expq.size() > 0) void'(expq.pop_front());
    end
  end
  initial begin
    #200000;
    errors++;
    end_sim;
  end
  initial begin
    repeat (12) @(posedge clock);
    rst <= '0;
    for (int j = 0; j < 24; j++) begin
      rs = xs(rs);
      @(posedge clock) channel_stop_bit <= '1;
      {oe, tm, interrupt_source_select, dap, cps, lsb, word_len_7} <= rs[6:0];
      nbits <= rs[0] ? 4'h7 : 4'h8;
      @(posedge clock) channel_stop_bit <= '0;
      tx_write <= '1;
      tx_data <= rs[23:16];
      @(posedge clock) tx_data <= rs[15:8];
      @(posedge clock) tx_write <= '0;
      repeat (3) @(posedge clock);
      @(posedge clock) channel_start <= '1;
      @(posedge clock) channel_start <= '0;
      m = word_len_7 ? 8'h7f : 8'hff;
      t = rs[15:8] & m;
      send(1'b1);
      chk((got & m) === (tm && oe ? (lsb ? rev(t, nbits) : t) : m), "tx bits");
    end
    tm <= '0;
    send(1'b0);
    rs = xs(rs);
    send(1'b0);
    chk(overrun_flag === 1'b1, "overrun");
    @(posedge clock) overrun_clear <= '1;
    rx_read <= '1;
    @(posedge clock) overrun_clear <= '0;
    rx_read <= '0;
    @(posedge clock) chk(overrun_flag === 1'b0 && expq.size() == 0, "clear");
    end_sim;
  end
endmodule
